// ===== rdos_selector.sv
// redundant output selector: picks station outputs from two controllers
// assumes controller frames and scan ticks arrive synchronous to sys_clk
// Contract
// - accept both output sets each scan
// - dual mode shares inputs with both controllers
// - primary mode follows controller 31
// - three missed scans switch to 30
// - no source: default or hold outputs
// - controller 31 reclaims whenever online
// - vote mode drives agreed value
// - disagreement drives configured fallback state
// - single sender drives outputs directly
// - analog station forces primary mode
// - bus config writes replace settings
`timescale 1ns/1ns
`include "rdos_params.svh"
module rdos_selector #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scan_tick,
  input wire logic frame_valid,
  input wire logic [4:0] frame_src,
  input wire logic [WIDTH-1:0] frame_data,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_data,
  input wire logic [WIDTH-1:0] station_inputs,
  input wire logic analog_present,
  output logic [WIDTH-1:0] station_outputs,
  output logic [WIDTH-1:0] share_inputs,
  output logic share_to_both,
  output logic [1:0] active_src,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rdos_pkg::*;

  // configuration and selection state
  logic [3:0] ctrl;
  logic [WIDTH-1:0] dflt, fallb, hold_p, hold_b;
  logic got_p, got_b;
  logic [1:0] miss_p, miss_b;
  rdos_src_t src;
  logic have_src;
  logic [3:0] next_ctrl;
  logic [WIDTH-1:0] next_dflt, next_fallb, next_hold_p, next_hold_b;
  logic [WIDTH-1:0] next_out;
  logic next_got_p, next_got_b, next_have_src;
  logic [1:0] next_miss_p, next_miss_b;
  rdos_src_t next_src;
  // bus slave state
  rdos_wr_t wst, next_wst;
  logic aw_hit, w_hit, next_aw_hit, next_w_hit;
  logic [7:0] aw_off, next_aw_off;
  logic [31:0] w_dat, next_w_dat;
  logic [3:0] w_stb, next_w_stb;
  logic [1:0] next_bresp, next_rresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic vote_mode, p_frm, b_frm, p_on, b_on;

  // byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (stb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // known register offset check
  function automatic logic mapped(input logic [7:0] off);
    mapped = (off == `RDOS_OFF_CTRL) || (off == `RDOS_OFF_DEFAULT) ||
      (off == `RDOS_OFF_FALLBACK) || (off == `RDOS_OFF_STATUS) ||
      (off == `RDOS_OFF_OUTPUT) || (off == `RDOS_OFF_INPUT);
  endfunction

  // frame source decode
  // fixed controller addresses
  assign p_frm = frame_valid && (frame_src == `RDOS_ADDR_PRIMARY);
  assign b_frm = frame_valid && (frame_src == `RDOS_ADDR_BACKUP);
  assign vote_mode = ctrl[`RDOS_CTRL_MODE] && !analog_present;
  assign share_inputs = station_inputs;
  assign share_to_both = ctrl[`RDOS_CTRL_DUAL];
  assign active_src = have_src ? src : 2'b00;
  // online at the coming tick: fresh frame, or the count after this
  // scan's increment still under the limit, so the third miss drops it
  assign p_on = got_p || (miss_p < (`RDOS_MISS_LIMIT - 2'd1));
  assign b_on = got_b || (miss_b < (`RDOS_MISS_LIMIT - 2'd1));

  // selection next values: frames and config taken any cycle, outputs chosen at each scan boundary
  always_comb
  begin
    logic [WIDTH-1:0] w;
    logic [31:0] cv;
    w = '0;
    cv = '0;
    next_ctrl = ctrl;
    next_dflt = dflt;
    next_fallb = fallb;
    next_hold_p = hold_p;
    next_hold_b = hold_b;
    next_got_p = got_p;
    next_got_b = got_b;
    next_miss_p = miss_p;
    next_miss_b = miss_b;
    next_src = src;
    next_have_src = have_src;
    next_out = station_outputs;
    if (p_frm)
    begin
      next_hold_p = frame_data;
      next_got_p = 1'b1;
      next_miss_p = 2'd0; // clear on arrival
    end
    if (b_frm)
    begin
      next_hold_b = frame_data;
      next_got_b = 1'b1;
      next_miss_b = 2'd0;
    end
    if (scan_tick)
    begin
      next_got_p = p_frm;
      next_got_b = b_frm;
      if (!got_p && !p_frm && miss_p != `RDOS_MISS_LIMIT)
        next_miss_p = miss_p + 2'd1;
      if (!got_b && !b_frm && miss_b != `RDOS_MISS_LIMIT)
        next_miss_b = miss_b + 2'd1;
      if (vote_mode)
      begin
        next_have_src = p_on || b_on;
        if (p_on && b_on)
        begin
          for (int i = 0; i < WIDTH; i++)
            w[i] = (hold_p[i] == hold_b[i]) ? hold_p[i] : fallb[i];
          next_out = w;
          next_src = RDOS_SRC_PRIMARY;
        end
        else if (p_on)
        begin
          next_out = hold_p;
          next_src = RDOS_SRC_PRIMARY;
        end
        else if (b_on)
        begin
          next_out = hold_b;
          next_src = RDOS_SRC_BACKUP;
        end
        else if (!ctrl[`RDOS_CTRL_RETAIN])
          next_out = dflt;
      end
      else
      begin
        if (p_on)
        begin
          next_src = RDOS_SRC_PRIMARY;
          next_have_src = 1'b1;
          next_out = hold_p;
        end
        else if (b_on)
        begin
          next_src = RDOS_SRC_BACKUP;
          next_have_src = 1'b1;
          next_out = hold_b;
        end
        else
        begin
          next_have_src = 1'b0;
          if (!ctrl[`RDOS_CTRL_RETAIN])
            next_out = dflt;
        end
      end
    end
    if (cfg_wr)
    begin
      if (cfg_addr == `RDOS_OFF_CTRL)
        next_ctrl = cfg_data[3:0];
      else if (cfg_addr == `RDOS_OFF_DEFAULT)
        next_dflt = cfg_data[WIDTH-1:0];
      else if (cfg_addr == `RDOS_OFF_FALLBACK)
        next_fallb = cfg_data[WIDTH-1:0];
    end
    // axi writes follow datagrams, so software wins a clash
    if (wst == RDOS_WR_IDLE && aw_hit && w_hit)
    begin
      if (aw_off == `RDOS_OFF_CTRL)
      begin
        cv = merge({28'h0000000, ctrl}, w_dat, w_stb);
        next_ctrl = cv[3:0];
      end
      else if (aw_off == `RDOS_OFF_DEFAULT)
      begin
        cv = merge(32'(dflt), w_dat, w_stb);
        next_dflt = cv[WIDTH-1:0];
      end
      else if (aw_off == `RDOS_OFF_FALLBACK)
      begin
        cv = merge(32'(fallb), w_dat, w_stb);
        next_fallb = cv[WIDTH-1:0];
      end
    end
  end

  // selection registers
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl <= 4'h0;
      dflt <= '0;
      fallb <= '0;
      hold_p <= '0;
      hold_b <= '0;
      got_p <= 1'b0;
      got_b <= 1'b0;
      miss_p <= `RDOS_MISS_LIMIT;
      miss_b <= `RDOS_MISS_LIMIT;
      src <= RDOS_SRC_PRIMARY;
      have_src <= 1'b0;
      station_outputs <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      dflt <= next_dflt;
      fallb <= next_fallb;
      hold_p <= next_hold_p;
      hold_b <= next_hold_b;
      got_p <= next_got_p;
      got_b <= next_got_b;
      miss_p <= next_miss_p;
      miss_b <= next_miss_b;
      src <= next_src;
      have_src <= next_have_src;
      station_outputs <= next_out;
    end
  end

  // axi handshakes: each address/data slot takes once, then waits
  assign s_axi_awready = !aw_hit && wst == RDOS_WR_IDLE;
  assign s_axi_wready = !w_hit && wst == RDOS_WR_IDLE;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bvalid = (wst == RDOS_WR_RESP);

  // axi slave next values
  always_comb
  begin
    next_wst = wst;
    next_aw_hit = aw_hit;
    next_w_hit = w_hit;
    next_aw_off = aw_off;
    next_w_dat = w_dat;
    next_w_stb = w_stb;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hit = 1'b1;
      next_aw_off = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hit = 1'b1;
      next_w_dat = s_axi_wdata;
      next_w_stb = s_axi_wstrb;
    end
    case (wst)
      RDOS_WR_IDLE:
        if (aw_hit && w_hit)
        begin
          next_wst = RDOS_WR_RESP;
          next_aw_hit = 1'b0;
          next_w_hit = 1'b0;
          if (aw_off == `RDOS_OFF_CTRL || aw_off == `RDOS_OFF_DEFAULT ||
              aw_off == `RDOS_OFF_FALLBACK)
            next_bresp = `RDOS_RESP_OKAY;
          else
            next_bresp = `RDOS_RESP_SLVERR;
        end
      RDOS_WR_RESP:
        if (s_axi_bready)
          next_wst = RDOS_WR_IDLE;
      default:
        next_wst = RDOS_WR_IDLE;
    endcase
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr[7:0]) ? `RDOS_RESP_OKAY :
        `RDOS_RESP_SLVERR;
      next_rdata = '0;
      if (s_axi_araddr[7:0] == `RDOS_OFF_CTRL)
        next_rdata = {28'h0000000, ctrl};
      else if (s_axi_araddr[7:0] == `RDOS_OFF_DEFAULT)
        next_rdata = 32'(dflt);
      else if (s_axi_araddr[7:0] == `RDOS_OFF_FALLBACK)
        next_rdata = 32'(fallb);
      else if (s_axi_araddr[7:0] == `RDOS_OFF_STATUS)
        next_rdata = {22'h000000, miss_b, miss_p, got_b, got_p,
          vote_mode, have_src, active_src};
      else if (s_axi_araddr[7:0] == `RDOS_OFF_OUTPUT)
        next_rdata = 32'(station_outputs);
      else if (s_axi_araddr[7:0] == `RDOS_OFF_INPUT)
        next_rdata = 32'(station_inputs);
    end
  end

  // axi slave registers
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wst <= RDOS_WR_IDLE;
      aw_hit <= 1'b0;
      w_hit <= 1'b0;
      aw_off <= 8'h00;
      w_dat <= 32'h00000000;
      w_stb <= 4'h0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      wst <= next_wst;
      aw_hit <= next_aw_hit;
      w_hit <= next_w_hit;
      aw_off <= next_aw_off;
      w_dat <= next_w_dat;
      w_stb <= next_w_stb;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // primary mode: primary online this scan selects primary next cycle
  property p_prim_wins;
    @(posedge sys_clk) disable iff (!rst_b)
    (scan_tick && !vote_mode && p_on) |=>
      (active_src == RDOS_SRC_PRIMARY) && (station_outputs == $past(hold_p));
  endproperty
  a_prim_wins: assert property (p_prim_wins)
    else $error("primary not selected");

  property p_reclaim;
    @(posedge sys_clk) disable iff (!rst_b)
    (scan_tick && !vote_mode && got_p && active_src == RDOS_SRC_BACKUP)
      |=> active_src == RDOS_SRC_PRIMARY;
  endproperty
  a_reclaim: assert property (p_reclaim)
    else $error("primary did not reclaim");

  property p_failover;
    @(posedge sys_clk) disable iff (!rst_b)
    (scan_tick && !vote_mode && !p_on && b_on) |=>
      active_src == RDOS_SRC_BACKUP;
  endproperty
  a_failover: assert property (p_failover)
    else $error("no failover to backup");

  property p_default;
    @(posedge sys_clk) disable iff (!rst_b)
    (scan_tick && !p_on && !b_on && !ctrl[`RDOS_CTRL_RETAIN]) |=>
      station_outputs == $past(dflt);
  endproperty
  a_default: assert property (p_default)
    else $error("defaults not applied");

  property p_vote;
    @(posedge sys_clk) disable iff (!rst_b)
    (scan_tick && vote_mode && p_on && b_on) |=>
      station_outputs ==
        (($past(hold_p) & ~($past(hold_p) ^ $past(hold_b))) |
        (($past(hold_p) ^ $past(hold_b)) & $past(fallb)));
  endproperty
  a_vote: assert property (p_vote)
    else $error("vote result wrong");

  property p_single;
    @(posedge sys_clk) disable iff (!rst_b)
    (scan_tick && vote_mode && !p_on && b_on) |=>
      station_outputs == $past(hold_b);
  endproperty
  a_single: assert property (p_single)
    else $error("lone sender not followed");

  property p_analog;
    @(posedge sys_clk) disable iff (!rst_b)
    (scan_tick && analog_present && p_on) |=>
      (active_src == RDOS_SRC_PRIMARY) && (station_outputs == $past(hold_p));
  endproperty
  a_analog: assert property (p_analog)
    else $error("vote allowed with analog");

  property p_miss_clr;
    @(posedge sys_clk) disable iff (!rst_b)
    p_frm |=> miss_p == 2'd0 ##1 (miss_p <= 2'd1);
  endproperty
  a_miss_clr: assert property (p_miss_clr)
    else $error("miss count not cleared");

  property p_cfg;
    @(posedge sys_clk) disable iff (!rst_b)
    (cfg_wr && cfg_addr == `RDOS_OFF_FALLBACK && !(wst == RDOS_WR_IDLE &&
      aw_hit && w_hit)) |=> fallb == $past(cfg_data[WIDTH-1:0]);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config write lost");
endmodule

// ===== rdos_params.svh
// timing and layout constants for the redundant output selector
// assumes inclusion by the design file, the partner model and the bench only
`ifndef RDOS_PARAMS_SVH
`define RDOS_PARAMS_SVH
`define RDOS_MISS_LIMIT 2'd3
`define RDOS_ADDR_PRIMARY 5'h1f
`define RDOS_ADDR_BACKUP 5'h1e
`define RDOS_OFF_CTRL 8'h00
`define RDOS_OFF_DEFAULT 8'h04
`define RDOS_OFF_FALLBACK 8'h08
`define RDOS_OFF_STATUS 8'h0c
`define RDOS_OFF_OUTPUT 8'h10
`define RDOS_OFF_INPUT 8'h14
`define RDOS_CTRL_MODE 0
`define RDOS_CTRL_RETAIN 1
`define RDOS_CTRL_DUAL 2
`define RDOS_CTRL_ANALOG 3
`define RDOS_RESP_OKAY 2'b00
`define RDOS_RESP_SLVERR 2'b10
`endif

// ===== rdos_pkg.sv
// types for the redundant output selector
// assumes rdos_params.svh sits in the include path
package rdos_pkg;
  typedef enum logic [1:0] {
    RDOS_SRC_PRIMARY = 2'b01,
    RDOS_SRC_BACKUP = 2'b10
  } rdos_src_t;
  typedef enum logic [1:0] {
    RDOS_WR_IDLE = 2'b01,
    RDOS_WR_RESP = 2'b10
  } rdos_wr_t;
endpackage

// ===== rdos_ctrl_pair.sv
// partner model: the two redundant bus controllers and the scan timer
// assumes the bench pulses go for one cycle to run one bus scan
`timescale 1ns/1ns
`include "rdos_params.svh"
module rdos_ctrl_pair (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic p_on,
  input wire logic b_on,
  input wire logic [15:0] p_dat,
  input wire logic [15:0] b_dat,
  output logic scan_tick,
  output logic frame_valid,
  output logic [4:0] frame_src,
  output logic [15:0] frame_data,
  output logic busy
);
  logic [2:0] cnt;
  logic [2:0] step;
  logic send;
  // scan phases: 1 primary frame, 2 backup frame, 3 tick, 4-6 settle
  assign step = (cnt == 3'd0) ? {2'b00, go} :
    (cnt == 3'd6) ? 3'd0 : cnt + 3'd1;
  assign send = (step == 3'd1 && p_on) || (step == 3'd2 && b_on);
  assign busy = (cnt != 3'd0);
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 3'd0;
      frame_valid <= 1'b0;
      scan_tick <= 1'b0;
      frame_src <= 5'h00;
      frame_data <= 16'h0000;
    end
    else
    begin
      cnt <= step;
      frame_valid <= send;
      scan_tick <= (step == 3'd3);
      if (send)
      begin
        frame_src <= (step == 3'd1) ? `RDOS_ADDR_PRIMARY :
          `RDOS_ADDR_BACKUP;
        frame_data <= (step == 3'd1) ? p_dat : b_dat;
      end
      else
      begin
        // released lines toggle so stale values never look valid
        frame_src <= ~frame_src;
        frame_data <= ~frame_data;
      end
    end
  end
endmodule

// ===== test_redundant_output_selector.sv
// self-checking bench for the redundant output selector
// assumes rdos_params.svh in the include path and a 16-bit output image
`timescale 1ns/1ns
`include "rdos_params.svh"
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_errors++; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end
module test_redundant_output_selector;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic scan_tick, frame_valid, busy, go = 1'b0, p_on = 1'b0, b_on = 1'b0;
  logic [4:0] frame_src;
  logic [15:0] frame_data, p_dat = 16'h0, b_dat = 16'h0;
  logic cfg_wr = 1'b0, analog_present = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_data = 32'h0;
  logic [15:0] station_inputs = 16'hbeef;
  logic [15:0] station_outputs, share_inputs;
  logic share_to_both;
  logic [1:0] active_src, s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  int n_errors = 0;
  int total_checks = 0;
  int i;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  rdos_selector #(.WIDTH(16)) u_rdos_selector (.*);
  rdos_ctrl_pair u_rdos_ctrl_pair (.*);

  // verdict and end of run
  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // bounded wait ran out
  task automatic timed_out(input int n);
    if (n >= 50)
    begin
      n_errors++;
      print_verdict();
    end
  endtask

  // one register write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    timed_out(n);
    `CHK("bresp", er, s_axi_bresp)
  endtask

  // one register read, data and response compared
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    timed_out(n);
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", ed, s_axi_rdata)
  endtask

  // one configuration datagram
  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
    cfg_addr <= a;
    cfg_data <= d;
    cfg_wr <= 1'b1;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one bus scan with the chosen senders, then outputs compared
  task automatic scan(input logic pe, input logic be,
    input logic [15:0] pd, input logic [15:0] bd,
    input logic [15:0] eo, input logic [1:0] es);
    int n;
    n = 0;
    p_on <= pe;
    b_on <= be;
    p_dat <= pd;
    b_dat <= bd;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (busy === 1'b1 && n < 50);
    timed_out(n);
    `CHK("station_outputs", eo, station_outputs)
    `CHK("active_src", es, active_src)
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    axi_rd(`RDOS_OFF_CTRL, 32'h0, `RDOS_RESP_OKAY);
    axi_rd(8'h20, 32'h0, `RDOS_RESP_SLVERR);
    axi_wr(`RDOS_OFF_OUTPUT, 32'h1, `RDOS_RESP_SLVERR);
    axi_wr(`RDOS_OFF_DEFAULT, 32'h00ff, `RDOS_RESP_OKAY);
    axi_wr(`RDOS_OFF_FALLBACK, 32'h0f0f, `RDOS_RESP_OKAY);
    scan(1, 1, 16'ha5a5, 16'h5a5a, 16'ha5a5, 2'b01);
    // primary silent: holds for two scans, backup on the third
    for (i = 1; i <= 3; i++)
      scan(0, 1, 16'h0, 16'h5a5a, (i < 3) ? 16'ha5a5 : 16'h5a5a,
        (i < 3) ? 2'b01 : 2'b10);
    scan(1, 1, 16'hc3c3, 16'h5a5a, 16'hc3c3, 2'b01);
    scan(0, 1, 16'h0, 16'h5a5a, 16'hc3c3, 2'b01);
    // both silent: primary holds once, backup once, then defaults
    scan(0, 0, 16'h0, 16'h0, 16'hc3c3, 2'b01);
    scan(0, 0, 16'h0, 16'h0, 16'h5a5a, 2'b10);
    scan(0, 0, 16'h0, 16'h0, 16'h00ff, 2'b00);
    axi_wr(`RDOS_OFF_CTRL, 32'h2, `RDOS_RESP_OKAY);
    scan(1, 0, 16'h1111, 16'h0, 16'h1111, 2'b01);
    for (i = 1; i <= 3; i++)
      scan(0, 0, 16'h0, 16'h0, 16'h1111, (i < 3) ? 2'b01 : 2'b00);
    // compare mode: agreed bits pass, others take fallback
    axi_wr(`RDOS_OFF_CTRL, 32'h1, `RDOS_RESP_OKAY);
    scan(1, 1, 16'h3c3c, 16'h3cc3, 16'h3c0f, 2'b01);
    // primary falls silent: vote goes on two scans, then backup alone
    for (i = 1; i <= 3; i++)
      scan(0, 1, 16'h0, 16'hc3c3, (i < 3) ? 16'h0f0f : 16'hc3c3,
        (i < 3) ? 2'b01 : 2'b10);
    analog_present <= 1'b1;
    scan(1, 1, 16'h7777, 16'h1111, 16'h7777, 2'b01);
    analog_present <= 1'b0;
    cfg_write(`RDOS_OFF_FALLBACK, 32'hf0f0);
    axi_rd(`RDOS_OFF_FALLBACK, 32'hf0f0, `RDOS_RESP_OKAY);
    scan(1, 1, 16'h0000, 16'hffff, 16'hf0f0, 2'b01);
    axi_rd(`RDOS_OFF_OUTPUT, 32'hf0f0, `RDOS_RESP_OKAY);
    axi_wr(`RDOS_OFF_CTRL, 32'h4, `RDOS_RESP_OKAY);
    `CHK("share_to_both", 1'b1, share_to_both)
    `CHK("share_inputs", 16'hbeef, share_inputs)
    axi_rd(`RDOS_OFF_INPUT, 32'hbeef, `RDOS_RESP_OKAY);
    axi_rd(`RDOS_OFF_STATUS, 32'h5, `RDOS_RESP_OKAY);
    print_verdict();
  end
endmodule
